// [verilog/dpct_map.svh]
// Register map, field positions, reset values and filter counts
`ifndef DPCT_MAP_SVH
`define DPCT_MAP_SVH

// Register indices; the byte address is four times the index
`define DPCT_IDX_NCTL  4'h0
`define DPCT_IDX_CMN   4'h1
`define DPCT_IDX_WCTL  4'h2
`define DPCT_IDX_SHR   4'h3
`define DPCT_IDX_NHLO  4'h4
`define DPCT_IDX_NHHI  4'h5
`define DPCT_IDX_WHLO  4'h6
`define DPCT_IDX_WHHI  4'h7
`define DPCT_IDX_WCLO  4'h8
`define DPCT_IDX_WCHI  4'h9
`define DPCT_IDX_NCLO  4'hA
`define DPCT_IDX_NCHI  4'hB

// Narrow and wide control fields
`define DPCT_B_EN      7
`define DPCT_B_SGL     6
`define DPCT_B_TO      5
`define DPCT_B_CLKH    4
`define DPCT_B_CLKL    3
`define DPCT_B_CIE     2
`define DPCT_B_TIE     1
`define DPCT_B_PIN     0

// Common control fields
`define DPCT_B_DEMOD   7
`define DPCT_B_INSEL   6
`define DPCT_B_EDGH    5
`define DPCT_B_EDGL    4
`define DPCT_B_GLH     3
`define DPCT_B_GLL     2
`define DPCT_B_INIT    1
`define DPCT_B_PP      0

// Shared control fields
`define DPCT_B_PEDGE   7
`define DPCT_B_NEDGE   6
`define DPCT_SHR_RSVD  5'h1F

// Reset values and counter constants
`define DPCT_RST_BYTE  8'h00
`define DPCT_UNMAPPED  8'h00
`define DPCT_WIDE_ONES 16'hFFFF
`define DPCT_NTC       8'h01
`define DPCT_WTC       16'h0001

// Least stable width, in clocks, for glitch codes 0 to 3
`define DPCT_GLITCH0   4'h1
`define DPCT_GLITCH1   4'h2
`define DPCT_GLITCH2   4'h4
`define DPCT_GLITCH3   4'h8

`endif

// [verilog/dpct_pkg.sv]
// Types shared by the counter/timer pair
package dpct_pkg;

   // Counter phase
   typedef enum logic [1:0] {
      PH_IDLE,
      PH_ARMED,
      PH_COUNT
   } dpct_phase_t;

   // Filtered edge pulses
   typedef struct packed {
      logic pos;
      logic neg;
   } dpct_edge_t;

   // Wide counter control fields kept as storage
   typedef struct packed {
      logic       single;
      logic [1:0] clk;
      logic       capIe;
      logic       toIe;
      logic       pinSel;
   } dpct_wctl_t;

endpackage

// [verilog/dpct_prescale.sv]
// Count-clock enable divider, divide by 1, 2, 4 or 8
`timescale 1ns/1ps
module dpct_prescale (
   input  wire logic       clock,  // System clock
   input  wire logic       rst,    // Synchronous reset
   input  wire logic       run,    // Counter running
   input  wire logic [1:0] sel,    // Divide code
   output wire logic       tick    // One-cycle count enable
);
   logic [2:0] cnt;
   wire  [2:0] mask = (3'h1 << sel) - 3'h1;

   // Tick when the low bits selected by the code are all ones
   assign tick = run & ((cnt & mask) == mask); // see RULE5

   // Free count, restarted while the counter is stopped
   always_ff @(posedge clock) begin
      if (rst | ~run) begin
         cnt <= 3'h0;
      end else begin
         cnt <= cnt + 3'h1;
      end
   end

   default clocking @(posedge clock); endclocking
   default disable iff (rst);

   div_spacing_a: assert property ( // see RULE5
      (tick && sel != 2'h0 && $stable(sel) && run) |=> !tick)
      else $error("divided tick came on consecutive cycles");
endmodule

// [verilog/dpct_edge_in.sv]
// Input select, glitch filter and edge detector
`timescale 1ns/1ps
`include "dpct_map.svh"
module dpct_edge_in (
   input  wire logic       clock,    // System clock
   input  wire logic       rst,      // Synchronous reset
   input  wire logic       pinA,     // First edge input pin
   input  wire logic       pinB,     // Second edge input pin
   input  wire logic       pinSel,   // 1 watches the second pin
   input  wire logic [1:0] width,    // Glitch width code
   input  wire logic [1:0] edgeSel,  // Bit 0 rising, bit 1 falling
   output dpct_pkg::dpct_edge_t edges // Edge pulses
);
   logic       filt;
   logic       filtD;
   logic [3:0] stab;

   wire        raw  = pinSel ? pinB : pinA;
   wire  [3:0] need = (width == 2'h0) ? `DPCT_GLITCH0 :
                      (width == 2'h1) ? `DPCT_GLITCH1 :
                      (width == 2'h2) ? `DPCT_GLITCH2 :
                                        `DPCT_GLITCH3;
   wire  [3:0] stabInc = stab + 4'h1;

   // Accept a new level only after it held long enough
   always_ff @(posedge clock) begin
      if (rst) begin
         filt  <= 1'b0;
         filtD <= 1'b0;
         stab  <= 4'h0;
      end else begin
         filtD <= filt;
         if (raw == filt) begin
            stab <= 4'h0;
         end else if (stabInc >= need) begin // see RULE11
            filt <= raw;
            stab <= 4'h0;
         end else begin
            stab <= stabInc;
         end
      end
   end

   // Edge pulses qualified by the selection
   assign edges.pos = filt & ~filtD & edgeSel[0]; // see RULE10
   assign edges.neg = ~filt & filtD & edgeSel[1]; // see RULE10

   default clocking @(posedge clock); endclocking
   default disable iff (rst);

   glitch_hold_a: assert property ( // see RULE11
      (raw != filt && stabInc < need) |=> $stable(filt))
      else $error("filter passed a short pulse");
endmodule

// [verilog/dpct_timer.sv]
// Dual down-counting timer pair with Avalon-MM register access
//
// How it works
// RULE1: wide enable bit reads run state, starts/stops
// RULE2: transmit: modulo reloads, single pass stops
// RULE3: demodulation: select bit enables edge recognition
// RULE4: wide timeout flag, write one clears
// RULE5: clock field divides by 1,2,4,8
// RULE6: capture interrupt gated by its enable
// RULE7: timeout interrupt gated by its enable
// RULE8: output pin carries port or wide output
// RULE9: shared low five bits read ones
// RULE10: edge detector picks pin and polarity
// RULE11: glitch filter drops too-narrow pulses
// RULE12: idle narrow output is inverse init bit
// RULE13: narrow wrap to all ones is no timeout
// RULE14: software stops, then clears status separately
// RULE15: narrow demod: first edge starts, later capture
// RULE16: initial one forbidden, zero wraps without timeout
// RULE17: wide demod: first edge captures, reloads, counts
// RULE18: later edges capture complement, flag, reload ones
// RULE19: software sets single pass, ping-pong, then enables
// RULE20: restart reloads the programmed initial value
// RULE21: software avoids hold writes during reload
// RULE22: clock field, capture enable survive stop recovery
// RULE23: terminal count sets flag and gated request
//
// Decided for this implementation: the Avalon-MM register port.
`timescale 1ns/1ps
`include "dpct_map.svh"
module dpct_timer (
   input  wire logic       clock,            // 40 MHz system clock
   input  wire logic       rst,              // Power-on reset
   input  wire logic       stopRecover,      // Stop-mode recovery pulse
   input  wire logic [5:0] address,          // Byte address
   input  wire logic       read,             // Read request
   input  wire logic       write,            // Write request
   input  wire logic [7:0] writedata,        // Write data
   output logic      [7:0] readdata,         // Read data
   output logic            waitrequest,      // Stall
   input  wire logic       edgeInputPinA,    // Edge input pin a
   input  wire logic       edgeInputPinB,    // Edge input pin b
   input  wire logic       portOutValue,     // Ordinary port value
   output logic            wideOutputPin,    // Shared output pin
   output logic            narrowOutput,     // Narrow counter output
   output logic            narrowTimeoutIrq, // Narrow timeout pulse
   output logic            wideTimeoutIrq,   // Wide timeout pulse
   output logic            wideCaptureIrq    // Wide capture pulse
);
   // Register storage
   logic                   nSingle;
   logic                   nTo;
   logic [1:0]             nClk;
   logic                   nToIe;
   logic [7:0]             cmn;
   dpct_pkg::dpct_wctl_t   wCtl;
   logic                   wTo;
   logic                   posSt;
   logic                   negSt;
   logic [7:0]             nHoldLo;
   logic [7:0]             nHoldHi;
   logic [7:0]             wHoldLo;
   logic [7:0]             wHoldHi;
   logic [15:0]            wCap;
   logic [7:0]             nCapLo;
   logic [7:0]             nCapHi;

   // Counter state
   dpct_pkg::dpct_phase_t  nPh;
   dpct_pkg::dpct_phase_t  wPh;
   dpct_pkg::dpct_phase_t  next_nPh;
   dpct_pkg::dpct_phase_t  next_wPh;
   logic [7:0]             nCount;
   logic [7:0]             next_nCount;
   logic                   next_nOut;
   logic [15:0]            wCount;
   logic [15:0]            next_wCount;
   logic                   wOut;
   logic                   next_wOut;
   logic                   nTick;
   logic                   wTick;
   dpct_pkg::dpct_edge_t   edgeEv;

   // Bus decode
   wire        busReq = read | write;
   wire        wrEn   = write & ~waitrequest;
   wire [3:0]  regIdx = address[5:2];
   wire        hitN   = wrEn & (regIdx == `DPCT_IDX_NCTL);
   wire        hitC   = wrEn & (regIdx == `DPCT_IDX_CMN);
   wire        hitW   = wrEn & (regIdx == `DPCT_IDX_WCTL);
   wire        hitS   = wrEn & (regIdx == `DPCT_IDX_SHR);
   wire        wdEn   = writedata[`DPCT_B_EN];

   // Mode and shared terms
   wire        demod  = cmn[`DPCT_B_DEMOD];
   wire        ppOn   = cmn[`DPCT_B_PP];
   wire        initB  = cmn[`DPCT_B_INIT];
   wire        anyEdge = edgeEv.pos | edgeEv.neg;
   wire [15:0] wHold  = {wHoldHi, wHoldLo};
   wire        nRun   = (nPh != dpct_pkg::PH_IDLE);
   wire        wRun   = (wPh != dpct_pkg::PH_IDLE);

   // Terminal count is the step from one; zero wraps silently
   wire nTcHit = nTick & (nPh == dpct_pkg::PH_COUNT)
                 & (nCount == `DPCT_NTC);           // see RULE13
   wire wTcHit = wTick & (wPh == dpct_pkg::PH_COUNT)
                 & (wCount == `DPCT_WTC);           // see RULE16

   // Start, stop and ping-pong hand-over
   wire nStop  = (hitN & ~wdEn) | stopRecover;       // see RULE1
   wire wStop  = (hitW & ~wdEn) | stopRecover;       // see RULE1
   wire nStart = ~nRun & ((hitN & wdEn) | (ppOn & wTcHit));
   wire wStart = ~wRun & ((hitW & wdEn) | (ppOn & nTcHit));

   // Wide and narrow edge handling in demodulation
   wire wRecog  = demod & ~wCtl.single;              // see RULE3
   wire wFirst  = demod & anyEdge & (wPh == dpct_pkg::PH_ARMED);
   wire wCapSub = wRecog & anyEdge & (wPh == dpct_pkg::PH_COUNT);
   wire nCapEv  = demod & (nPh == dpct_pkg::PH_COUNT);

   // Read selection
   wire [7:0] rdNctl = {nRun, nSingle, nTo, nClk, 1'b0, nToIe, 1'b0};
   wire [7:0] rdWctl = {wRun, wCtl.single, wTo, wCtl.clk,
                        wCtl.capIe, wCtl.toIe, wCtl.pinSel}; // see RULE1
   wire [7:0] rdShr  = {posSt, negSt, 1'b0, `DPCT_SHR_RSVD}; // see RULE9
   wire [7:0] rdMux  =
      (regIdx == `DPCT_IDX_NCTL) ? rdNctl :
      (regIdx == `DPCT_IDX_CMN)  ? cmn :
      (regIdx == `DPCT_IDX_WCTL) ? rdWctl :
      (regIdx == `DPCT_IDX_SHR)  ? rdShr :
      (regIdx == `DPCT_IDX_NHLO) ? nHoldLo :
      (regIdx == `DPCT_IDX_NHHI) ? nHoldHi :
      (regIdx == `DPCT_IDX_WHLO) ? wHoldLo :
      (regIdx == `DPCT_IDX_WHHI) ? wHoldHi :
      (regIdx == `DPCT_IDX_WCLO) ? wCap[7:0] :
      (regIdx == `DPCT_IDX_WCHI) ? wCap[15:8] :
      (regIdx == `DPCT_IDX_NCLO) ? nCapLo :
      (regIdx == `DPCT_IDX_NCHI) ? nCapHi : `DPCT_UNMAPPED;

   // Count-clock dividers
   dpct_prescale u_nPre (
      .clock (clock),
      .rst   (rst),
      .run   (nRun),
      .sel   (nClk),
      .tick  (nTick)
   );

   dpct_prescale u_wPre (
      .clock (clock),
      .rst   (rst),
      .run   (wRun),
      .sel   (wCtl.clk),
      .tick  (wTick)
   );

   // Input filter and edge detector
   dpct_edge_in u_edge (
      .clock   (clock),
      .rst     (rst),
      .pinA    (edgeInputPinA),
      .pinB    (edgeInputPinB),
      .pinSel  (cmn[`DPCT_B_INSEL]),
      .width   (cmn[`DPCT_B_GLH:`DPCT_B_GLL]),
      .edgeSel (cmn[`DPCT_B_EDGH:`DPCT_B_EDGL]),
      .edges   (edgeEv)
   );

   // One wait cycle, then the access completes
   always_ff @(posedge clock) begin
      if (rst) begin
         waitrequest <= 1'b1;
         readdata    <= `DPCT_RST_BYTE;
      end else begin
         waitrequest <= ~(busReq & waitrequest);
         if (read & waitrequest) readdata <= rdMux;
      end
   end

   // Narrow counter next state
   always_comb begin
      next_nPh    = nPh;
      next_nCount = nCount;
      next_nOut   = narrowOutput;
      if (nStop) begin
         next_nPh = dpct_pkg::PH_IDLE;
      end else if (nStart) begin
         next_nPh    = demod ? dpct_pkg::PH_ARMED : dpct_pkg::PH_COUNT;
         next_nOut   = initB;
         next_nCount = initB ? nHoldHi : nHoldLo;    // see RULE20
      end else begin
         case (nPh)
            dpct_pkg::PH_ARMED: begin
               if (anyEdge) next_nPh = dpct_pkg::PH_COUNT; // see RULE15
            end
            dpct_pkg::PH_COUNT: begin
               if (nTcHit) begin
                  if (demod | nSingle) begin
                     next_nPh = dpct_pkg::PH_IDLE;
                  end else begin
                     next_nOut   = ~narrowOutput;
                     next_nCount = narrowOutput ? nHoldLo : nHoldHi;
                  end
               end else if (nTick) begin
                  next_nCount = nCount - 8'h01;
               end
            end
            default: ;
         endcase
      end
      if (nPh == dpct_pkg::PH_IDLE && !nStart) begin
         next_nOut = ~initB;                         // see RULE12
      end
   end

   // Wide counter next state
   always_comb begin
      next_wPh    = wPh;
      next_wCount = wCount;
      next_wOut   = wOut;
      if (wStop) begin
         next_wPh = dpct_pkg::PH_IDLE;
      end else if (wStart) begin
         next_wPh    = demod ? dpct_pkg::PH_ARMED : dpct_pkg::PH_COUNT;
         next_wCount = wHold;                        // see RULE20
      end else begin
         case (wPh)
            dpct_pkg::PH_ARMED: begin
               if (wFirst) begin                     // see RULE17
                  next_wPh    = dpct_pkg::PH_COUNT;
                  next_wCount = wHold;
               end
            end
            dpct_pkg::PH_COUNT: begin
               if (wCapSub) begin
                  next_wCount = `DPCT_WIDE_ONES;     // see RULE18
               end else if (wTcHit) begin
                  if (demod | wCtl.single) begin     // see RULE2
                     next_wPh = dpct_pkg::PH_IDLE;
                  end else begin
                     next_wCount = wHold;            // see RULE2
                     next_wOut   = ~wOut;
                  end
               end else if (wTick) begin
                  next_wCount = wCount - 16'h0001;   // see RULE16
               end
            end
            default: ;
         endcase
      end
   end

   // Counter registers
   always_ff @(posedge clock) begin
      if (rst) begin
         nPh          <= dpct_pkg::PH_IDLE;
         wPh          <= dpct_pkg::PH_IDLE;
         nCount       <= `DPCT_RST_BYTE;
         wCount       <= {`DPCT_RST_BYTE, `DPCT_RST_BYTE};
         narrowOutput <= 1'b1;
         wOut         <= 1'b0;
      end else begin
         nPh          <= next_nPh;
         wPh          <= next_wPh;
         nCount       <= next_nCount;
         wCount       <= next_wCount;
         narrowOutput <= next_nOut;
         wOut         <= next_wOut;
      end
   end

   // Capture registers
   always_ff @(posedge clock) begin
      if (rst) begin
         wCap   <= {`DPCT_RST_BYTE, `DPCT_RST_BYTE};
         nCapLo <= `DPCT_RST_BYTE;
         nCapHi <= `DPCT_RST_BYTE;
      end else begin
         if (wFirst | wCapSub) wCap <= ~wCount;      // see RULE18
         if (nCapEv & edgeEv.pos) nCapHi <= ~nCount; // see RULE15
         if (nCapEv & edgeEv.neg) nCapLo <= ~nCount; // see RULE15
      end
   end

   // Hold and common control registers
   always_ff @(posedge clock) begin
      if (rst) begin
         cmn     <= `DPCT_RST_BYTE;
         nHoldLo <= `DPCT_RST_BYTE;
         nHoldHi <= `DPCT_RST_BYTE;
         wHoldLo <= `DPCT_RST_BYTE;
         wHoldHi <= `DPCT_RST_BYTE;
      end else begin
         if (hitC) cmn <= writedata;
         if (wrEn && regIdx == `DPCT_IDX_NHLO) nHoldLo <= writedata;
         if (wrEn && regIdx == `DPCT_IDX_NHHI) nHoldHi <= writedata;
         if (wrEn && regIdx == `DPCT_IDX_WHLO) wHoldLo <= writedata;
         if (wrEn && regIdx == `DPCT_IDX_WHHI) wHoldHi <= writedata;
      end
   end

   // Narrow control; recovery clears it
   always_ff @(posedge clock) begin
      if (rst | stopRecover) begin
         nSingle <= 1'b0;
         nClk    <= 2'h0;
         nToIe   <= 1'b0;
      end else if (hitN) begin
         nSingle <= writedata[`DPCT_B_SGL];
         nClk    <= writedata[`DPCT_B_CLKH:`DPCT_B_CLKL];
         nToIe   <= writedata[`DPCT_B_TIE];
      end
   end

   // Wide fields that stop recovery leaves alone
   always_ff @(posedge clock) begin
      if (rst) begin                                 // see RULE22
         wCtl.clk   <= 2'h0;
         wCtl.capIe <= 1'b0;
      end else if (hitW) begin
         wCtl.clk   <= writedata[`DPCT_B_CLKH:`DPCT_B_CLKL]; // see RULE5
         wCtl.capIe <= writedata[`DPCT_B_CIE];       // see RULE6
      end
   end

   // Wide fields that stop recovery clears
   always_ff @(posedge clock) begin
      if (rst | stopRecover) begin
         wCtl.single <= 1'b0;
         wCtl.toIe   <= 1'b0;
         wCtl.pinSel <= 1'b0;
      end else if (hitW) begin
         wCtl.single <= writedata[`DPCT_B_SGL];
         wCtl.toIe   <= writedata[`DPCT_B_TIE];      // see RULE7
         wCtl.pinSel <= writedata[`DPCT_B_PIN];      // see RULE8
      end
   end

   // Sticky status; a setting event wins over the clear
   always_ff @(posedge clock) begin
      if (rst | stopRecover) begin
         nTo   <= 1'b0;
         wTo   <= 1'b0;
         posSt <= 1'b0;
         negSt <= 1'b0;
      end else begin
         if (nTcHit) nTo <= 1'b1;                    // see RULE23
         else if (hitN & writedata[`DPCT_B_TO]) nTo <= 1'b0;
         if (wTcHit) wTo <= 1'b1;                    // see RULE4
         else if (hitW & writedata[`DPCT_B_TO]) wTo <= 1'b0; // see RULE4
         if (wCapSub & edgeEv.pos) posSt <= 1'b1;    // see RULE18
         else if (hitS & writedata[`DPCT_B_PEDGE]) posSt <= 1'b0;
         if (wCapSub & edgeEv.neg) negSt <= 1'b1;    // see RULE18
         else if (hitS & writedata[`DPCT_B_NEDGE]) negSt <= 1'b0;
      end
   end

   // Interrupt pulses and output pin
   always_ff @(posedge clock) begin
      if (rst) begin
         narrowTimeoutIrq <= 1'b0;
         wideTimeoutIrq   <= 1'b0;
         wideCaptureIrq   <= 1'b0;
         wideOutputPin    <= 1'b0;
      end else begin
         narrowTimeoutIrq <= nTcHit & nToIe;         // see RULE23
         wideTimeoutIrq   <= wTcHit & wCtl.toIe;     // see RULE7
         wideCaptureIrq   <= wCapSub & wCtl.capIe;   // see RULE6
         wideOutputPin    <= wCtl.pinSel ? wOut : portOutValue; // see RULE8
      end
   end

   default clocking @(posedge clock); endclocking
   default disable iff (rst);

   run_readback_a: assert property ( // see RULE1
      (regIdx == `DPCT_IDX_WCTL) |-> (rdMux[7] == wRun))
      else $error("enable bit does not show run state");

   modulo_reload_a: assert property ( // see RULE2
      (wTcHit && !demod && !wCtl.single && !wStop && !wStart)
      |=> (wCount == $past(wHold)) && (wPh == dpct_pkg::PH_COUNT))
      else $error("modulo count did not reload");

   single_stop_a: assert property ( // see RULE2
      (wTcHit && wCtl.single && !wCapSub && !wStart)
      |=> (wPh == dpct_pkg::PH_IDLE))
      else $error("single pass did not stop");

   timeout_set_a: assert property ( // see RULE4
      (wTcHit && !stopRecover)
      |=> wTo ##0 wideTimeoutIrq == $past(wCtl.toIe))
      else $error("timeout flag or request missing");

   cap_gate_a: assert property ( // see RULE6
      wideCaptureIrq |-> $past(wCtl.capIe && wCapSub))
      else $error("capture request without enable");

   pin_select_a: assert property ( // see RULE8
      ##1 wideOutputPin == $past(wCtl.pinSel ? wOut : portOutValue))
      else $error("output pin source wrong");

   reserved_ones_a: assert property ( // see RULE9
      (regIdx == `DPCT_IDX_SHR) |-> (rdMux[4:0] == `DPCT_SHR_RSVD))
      else $error("reserved bits not all ones");

   idle_level_a: assert property ( // see RULE12
      (nPh == dpct_pkg::PH_IDLE && !nStart && !rst)
      |=> narrowOutput == !$past(initB))
      else $error("idle narrow output not inverse of init");

   wrap_quiet_a: assert property ( // see RULE16
      (wPh == dpct_pkg::PH_COUNT && wCount == 16'h0000 && !wTo
       && !stopRecover) |=> !wTo)
      else $error("wrap from zero raised timeout");

   edge_capture_a: assert property ( // see RULE18
      (wCapSub && !wStop && !wStart)
      |=> (wCap == ~$past(wCount)) && (wCount == `DPCT_WIDE_ONES))
      else $error("edge capture or reload wrong");
endmodule

// [verif/dpct_pulse_src.sv]
// Far-side pulse source driving the edge input pins
`timescale 1ns/1ps
module dpct_pulse_src (
   input  wire logic       clock, // System clock
   input  wire logic       go,    // Start one pulse
   input  wire logic [3:0] len,   // Pulse width in clocks
   output logic            pinA,  // Pulse on first pin
   output logic            pinB   // Second pin, idle low
);
   logic [3:0] left = 4'h0;
   // Count down the clocks left in the pulse
   always @(posedge clock) begin
      if (go) begin
         left <= len;
      end else if (left != 4'h0) begin
         left <= left - 4'h1;
      end
   end
   // Narrow widths probe the glitch filter
   assign pinA = (left != 4'h0);
   assign pinB = 1'b0;
endmodule

// [verif/dpct_timer_tb.sv]
// Self-checking bench for the counter/timer pair
`timescale 1ns/1ps
module dpct_timer_tb;
   typedef struct packed {
      logic [5:0] a;
      logic [7:0] d;
      logic [7:0] e;
   } dpct_row_t;
   logic       clock, rst, stopRecover, read, write, go, portOutValue;
   logic [5:0] address;
   logic [7:0] writedata, readdata, v;
   logic [3:0] pLen;
   logic       waitrequest, pinA, pinB, wideOutputPin, narrowOutput;
   logic       nIrq, wToIrq, wCapIrq;
   int         errors, n_compared, cyc, c;
   logic [7:0] nIrqs = 8'h00, nCaps = 8'h00, k;
   dpct_row_t  rows [6];

   dpct_timer u_dpct_timer (.clock(clock), .rst(rst),
      .stopRecover(stopRecover), .address(address), .read(read),
      .write(write), .writedata(writedata), .readdata(readdata),
      .waitrequest(waitrequest), .edgeInputPinA(pinA),
      .edgeInputPinB(pinB), .portOutValue(portOutValue),
      .wideOutputPin(wideOutputPin), .narrowOutput(narrowOutput),
      .narrowTimeoutIrq(nIrq), .wideTimeoutIrq(wToIrq),
      .wideCaptureIrq(wCapIrq));
   dpct_pulse_src u_dpct_pulse_src (.clock(clock), .go(go), .len(pLen),
      .pinA(pinA), .pinB(pinB));

   // Clock and hang guard
   initial begin
      clock = 1'b0;
      forever #12.5 clock = ~clock;
   end
   always @(posedge clock) begin
      cyc++;
      if (!rst) begin
         nIrqs <= nIrqs + {7'h00, nIrq};
         nCaps <= nCaps + {7'h00, wCapIrq};
      end
      if (cyc == 20000) begin
         errors++;
         results();
      end
   end

   // Bus cycles, compares and waits
   task automatic acc(input logic w, input logic [5:0] a,
                      input logic [7:0] d);
      address <= a;
      writedata <= d;
      write <= w;
      read <= ~w;
      @(posedge clock);
      while (waitrequest !== 1'b0) @(posedge clock);
      v = readdata;
      write <= 1'b0;
      read <= 1'b0;
      @(posedge clock);
   endtask
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_compared++;
      if (got !== exp) begin
         errors++;
         $display("FAIL %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic waitp(input logic cap, input int lim);
      c = 0;
      do begin
         @(posedge clock);
         c++;
      end while ((cap ? wCapIrq : wToIrq) !== 1'b1 && c < lim);
   endtask
   task automatic pulse(input logic [3:0] w);
      pLen <= w;
      go <= 1'b1;
      @(posedge clock);
      go <= 1'b0;
      repeat (20) @(posedge clock);
   endtask
   task automatic results();
      $display("compared %0d mismatches %0d", n_compared, errors);
      if (errors == 0 && n_compared > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   // Register table rows: write, read back, expected value
   initial begin
      rows[0] = '{6'h0C, 8'h00, 8'h1F};
      rows[1] = '{6'h0C, 8'hFF, 8'h1F};
      rows[2] = '{6'h08, 8'h1E, 8'h1E};
      rows[3] = '{6'h08, 8'h01, 8'h01};
      rows[4] = '{6'h30, 8'hFF, 8'h00};
      rows[5] = '{6'h18, 8'hA5, 8'hA5};
      {rst, stopRecover, read, write, go, portOutValue} = 6'h20;
      {address, writedata, pLen} = '0;
      repeat (2) @(posedge clock);
      rst <= 1'b0;
      @(posedge clock);
      chk({7'h00, narrowOutput}, 8'h01);
      acc(0, 6'h08, 8'h00); chk(v, 8'h00);
      foreach (rows[i]) begin
         acc(1, rows[i].a, rows[i].d);
         acc(0, rows[i].a, 8'h00); chk(v, rows[i].e);
      end
      $display("register rows done");
      acc(1, 6'h04, 8'h02);
      @(posedge clock);
      chk({7'h00, narrowOutput}, 8'h00);
      acc(1, 6'h08, 8'h00);
      portOutValue <= 1'b1;
      repeat (2) @(posedge clock);
      chk({7'h00, wideOutputPin}, 8'h01);
      acc(1, 6'h08, 8'h01);
      repeat (2) @(posedge clock);
      chk({7'h00, wideOutputPin}, 8'h00);
      // Modulo periods for every divide code, hold of three
      acc(1, 6'h18, 8'h03);
      acc(1, 6'h1C, 8'h00);
      for (int i = 0; i < 4; i++) begin
         acc(1, 6'h08, {3'b100, i[1:0], 3'b010});
         waitp(0, 100);
         waitp(0, 100); chk(c[7:0], 8'h03 << i);
         acc(0, 6'h08, 8'h00); chk(v & 8'h80, 8'h80);
         acc(1, 6'h08, 8'h02);
      end
      acc(0, 6'h08, 8'h00); chk(v, 8'h22);
      acc(1, 6'h08, 8'h20);
      acc(0, 6'h08, 8'h00); chk(v, 8'h00);
      acc(1, 6'h08, 8'hC2);
      waitp(0, 100);
      waitp(0, 50); chk(c[7:0], 8'h32);
      acc(0, 6'h08, 8'h00); chk(v, 8'h62);
      acc(1, 6'h08, 8'hA0);
      waitp(0, 40); chk(c[7:0], 8'h28);
      $display("transmit tests done");
      // Ping-pong: both stopped and single, then start the narrow one
      acc(1, 6'h08, 8'h42);
      acc(1, 6'h00, 8'h42);
      acc(1, 6'h10, 8'h02);
      acc(1, 6'h04, 8'h01);
      acc(1, 6'h00, 8'hC2);
      waitp(0, 100);
      k = nIrqs;
      waitp(0, 100);
      chk(c[7:0], 8'h05);
      chk(nIrqs - k, 8'h01);
      acc(1, 6'h04, 8'h00);
      $display("ping-pong test done");
      // Wide demodulation on rising edges of the first pin
      acc(1, 6'h08, 8'h00);
      acc(1, 6'h04, 8'h90);
      acc(1, 6'h18, 8'hFF);
      acc(1, 6'h1C, 8'hFF);
      acc(1, 6'h08, 8'h84);
      pulse(4'h4);
      pulse(4'h4);
      acc(0, 6'h0C, 8'h00); chk(v, 8'h9F);
      acc(0, 6'h24, 8'h00); chk(v, 8'h00);
      acc(0, 6'h20, 8'h00); chk(v, 8'h14);
      acc(1, 6'h0C, 8'h80);
      acc(1, 6'h08, 8'h00);
      acc(1, 6'h08, 8'hC4);
      pulse(4'h4);
      pulse(4'h4);
      acc(0, 6'h0C, 8'h00); chk(v, 8'h1F);
      acc(1, 6'h08, 8'h00);
      acc(1, 6'h04, 8'h9C);
      acc(1, 6'h08, 8'h84);
      pulse(4'hC);
      pulse(4'h3);
      acc(0, 6'h0C, 8'h00); chk(v, 8'h1F);
      chk(nCaps, 8'h01);
      $display("demodulation tests done");
      // Stop recovery keeps divider and capture enable
      acc(1, 6'h08, 8'h1E);
      stopRecover <= 1'b1;
      @(posedge clock);
      stopRecover <= 1'b0;
      acc(0, 6'h08, 8'h00); chk(v, 8'h1C);
      $display("recovery test done");
      results();
   end
endmodule
